// File: rtl/mmrd_cfg.svh
// Purpose: constants for the memory mapped register decode
// Assumes: 8-bit data address space, 12-bit program address space
// Notes:   offsets, field positions, reset values
//
// Summary of operation
// - ports, peripheral and core registers sit in data space; accumulator and pc do not
// - interrupt vectors fetched from fixed program addresses 0xFF6 through 0xFFE
// - volatile oscillator trim at 0xBA, stored copy at 0xBC
// - volatile init config at 0xB9, stored copy at 0xBB, two locations
// - volatile analog trim at 0xD0, stored copy at 0xD1
// - volatile port default trim at 0xD3, stored copy at 0xD4
// - power mode clear register sits at 0xC0
// - system reset reloads volatile oscillator trim with factory value
// - in core status only one bit is writable by software: data bit 7 sets GIE, which reads back at bit 4
// - init registers other than volatile oscillator trim (0xBA) accessible only in programming mode
`ifndef MMRD_CFG_SVH
`define MMRD_CFG_SVH

`define MMRD_SRAM_LO      8'h00
`define MMRD_SRAM_HI      8'h3F
`define MMRD_EE_LO        8'h40
`define MMRD_EE_HI        8'h7F

`define MMRD_ADC_RESULT   8'h9D
`define MMRD_ADC_CTL_A    8'h9F
`define MMRD_ADC_CTL_B    8'hA0
`define MMRD_CMP_DELAY    8'hA2
`define MMRD_PWM_PWM_PRESCALE_CONTROL   8'hA4
`define MMRD_PWM_PWM_DEAD_TIME    8'hA5
`define MMRD_PWM_CMPA_LO  8'hA6
`define MMRD_PWM_CMPA_HI  8'hA7
`define MMRD_PWM_CMPB_LO  8'hA8
`define MMRD_PWM_CMPB_HI  8'hA9
`define MMRD_PWM_RLD_LO   8'hAA
`define MMRD_PWM_RLD_HI   8'hAB
`define MMRD_PWM_CNT_LO   8'hAC
`define MMRD_PWM_CNT_HI   8'hAD
`define MMRD_PWM_CTL      8'hAE
`define MMRD_WK_EDGE      8'hAF
`define MMRD_WK_PEND      8'hB0
`define MMRD_WK_EN        8'hB1
`define MMRD_PORT_OUT     8'hB2
`define MMRD_PORT_DIR     8'hB3
`define MMRD_PORT_PIN     8'hB4
`define MMRD_WD_SVC       8'hB5
`define MMRD_TICK_CTL     8'hB6
`define MMRD_LPM_CTL      8'hB7
`define MMRD_INIT_VOL     8'hB9
`define MMRD_TRIM_VOL     8'hBA
`define MMRD_INIT_STO     8'hBB
`define MMRD_TRIM_STO     8'hBC
`define MMRD_CMP_LEVEL    8'hBD
`define MMRD_IDX_HI       8'hBE
`define MMRD_IDX_LO       8'hBF
`define MMRD_PMC          8'hC0
`define MMRD_SP           8'hCE
`define MMRD_STATUS       8'hCF
`define MMRD_ATRIM_VOL    8'hD0
`define MMRD_ATRIM_STO    8'hD1
`define MMRD_PART_ID      8'hD2
`define MMRD_PTRIM_VOL    8'hD3
`define MMRD_PTRIM_STO    8'hD4

`define MMRD_VEC_TICK     12'hFF6
`define MMRD_VEC_PWM      12'hFF8
`define MMRD_VEC_WAKE     12'hFFA
`define MMRD_VEC_SWI      12'hFFC
`define MMRD_VEC_ADC      12'hFFE

`define MMRD_STATUS_GIE   7
`define MMRD_TRIM_FACTORY 8'h80
`define MMRD_RST_ZERO     8'h00

`endif

// File: rtl/mmrd_pkg.sv
// Purpose: types for the memory mapped register decode
// Assumes: nothing
// Notes:   request and answer carriers
package mmrd_pkg;

   typedef enum logic [4:0] {
      MMRD_VEC_TICK_E = 5'h01,
      MMRD_VEC_PWM_E  = 5'h02,
      MMRD_VEC_WAKE_E = 5'h04,
      MMRD_VEC_SWI_E  = 5'h08,
      MMRD_VEC_ADC_E  = 5'h10
   } mmrd_vec_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mmrd_req_t;

   typedef struct packed {
      logic [7:0] rdata;
      logic       sram_sel;
      logic       ee_sel;
      logic       hit;
   } mmrd_rsp_t;

   typedef struct packed {
      logic [7:0] status_flags;
      logic [7:0] adc_result;
      logic [11:0] pwm_count;
      logic [7:0] pin_level;
      logic [1:0] cmp_status;
   } mmrd_hw_t;

endpackage

// File: rtl/mmrd_decode.sv
// Purpose: data space register file and vector address decode
// Assumes: core load/store path, one access per cycle
// Notes:   read data one cycle after request
`timescale 1ns/1ns
`default_nettype none
`include "mmrd_cfg.svh"

module mmrd_decode #(
   parameter logic [7:0] PART_ID = 8'h5A   // arbitrary value
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst_b,
   input  wire mmrd_pkg::mmrd_req_t i_req,
   input  wire logic              i_prog_mode,
   input  wire mmrd_pkg::mmrd_hw_t  i_hw,
   input  wire mmrd_pkg::mmrd_vec_t i_vec_sel,
   output var  mmrd_pkg::mmrd_rsp_t o_rsp,
   output logic [11:0]            o_vec_addr,
   output logic [7:0]             o_trim_vol,
   output logic [7:0]             o_init_vol,
   output logic [7:0]             o_port_out,
   output logic [7:0]             o_port_dir,
   output logic                   o_gie,
   output logic                   o_pmc_strobe
);
   import mmrd_pkg::*;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   localparam int NREG = 38;
   logic [7:0] regs_q [NREG];
   logic [7:0] addr_tab [NREG];
   assign addr_tab = '{`MMRD_ADC_RESULT, `MMRD_ADC_CTL_A, `MMRD_ADC_CTL_B,
      `MMRD_CMP_DELAY, `MMRD_PWM_PWM_PRESCALE_CONTROL, `MMRD_PWM_PWM_DEAD_TIME, `MMRD_PWM_CMPA_LO,
      `MMRD_PWM_CMPA_HI, `MMRD_PWM_CMPB_LO, `MMRD_PWM_CMPB_HI,
      `MMRD_PWM_RLD_LO, `MMRD_PWM_RLD_HI, `MMRD_PWM_CNT_LO,
      `MMRD_PWM_CNT_HI, `MMRD_PWM_CTL, `MMRD_WK_EDGE, `MMRD_WK_PEND,
      `MMRD_WK_EN, `MMRD_PORT_OUT, `MMRD_PORT_DIR, `MMRD_PORT_PIN,
      `MMRD_WD_SVC, `MMRD_TICK_CTL, `MMRD_LPM_CTL, `MMRD_INIT_VOL,
      `MMRD_TRIM_VOL, `MMRD_INIT_STO, `MMRD_TRIM_STO, `MMRD_CMP_LEVEL,
      `MMRD_IDX_HI, `MMRD_IDX_LO, `MMRD_PMC, `MMRD_SP, `MMRD_STATUS,
      `MMRD_ATRIM_VOL, `MMRD_ATRIM_STO, `MMRD_PTRIM_VOL, `MMRD_PTRIM_STO};

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic is_init(input logic [7:0] a);
      is_init = (a == `MMRD_INIT_VOL) || (a == `MMRD_INIT_STO) ||
                (a == `MMRD_TRIM_STO) || (a == `MMRD_ATRIM_VOL) ||
                (a == `MMRD_ATRIM_STO) || (a == `MMRD_PTRIM_VOL) ||
                (a == `MMRD_PTRIM_STO);
   endfunction

   function automatic logic is_ro(input logic [7:0] a);
      is_ro = (a == `MMRD_ADC_RESULT) || (a == `MMRD_PWM_CNT_LO) ||
              (a == `MMRD_PWM_CNT_HI) || (a == `MMRD_PORT_PIN) ||
              (a == `MMRD_PART_ID);
   endfunction

   logic [7:0] reg_hit;
   logic       any_hit;
   logic [5:0] hit_idx;
   always_comb begin
      any_hit = 1'b0;
      hit_idx = 6'h00;
      reg_hit = 8'h00;
      for (int i = 0; i < NREG; i++) begin
         if (addr_tab[i] == i_req.addr) begin
            any_hit = 1'b1;
            hit_idx = 6'(i);
         end
      end
      if (is_init(i_req.addr) && !i_prog_mode) begin
         any_hit = 1'b0;
      end
      reg_hit = {7'h00, any_hit};
   end

   logic id_hit;
   assign id_hit = (i_req.addr == `MMRD_PART_ID);

   logic trim_access_ok;
   // volatile trim writable with clock adjust enabled or in programming mode
   assign trim_access_ok = i_prog_mode | regs_q[24][7];

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         for (int i = 0; i < NREG; i++) begin
            regs_q[i] <= `MMRD_RST_ZERO;
         end
         regs_q[25] <= `MMRD_TRIM_FACTORY;
      end else begin
         // mirror hardware state into read-only slots
         regs_q[0]  <= i_hw.adc_result;
         regs_q[12] <= i_hw.pwm_count[7:0];
         regs_q[13] <= {4'h0, i_hw.pwm_count[11:8]};
         regs_q[20] <= i_hw.pin_level;
         regs_q[33] <= {i_hw.status_flags[7], 2'b00, regs_q[33][4],
                        i_hw.status_flags[3:0]};
         regs_q[28][1:0] <= i_hw.cmp_status;
         if (i_req.wr && reg_hit[0] && !is_ro(i_req.addr)) begin
            if (hit_idx == 6'd33) begin
               regs_q[33][4] <= i_req.wdata[`MMRD_STATUS_GIE];
            end else if (hit_idx == 6'd28) begin
               regs_q[28][7:2] <= i_req.wdata[7:2];
            end else if (hit_idx == 6'd25) begin
               if (trim_access_ok) begin
                  regs_q[25] <= i_req.wdata;
               end
            end else begin
               regs_q[hit_idx] <= i_req.wdata;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_rsp <= '0;
      end else begin
         o_rsp.sram_sel <= (i_req.rd | i_req.wr) && (i_req.addr <= `MMRD_SRAM_HI);
         o_rsp.ee_sel   <= (i_req.rd | i_req.wr) && (i_req.addr >= `MMRD_EE_LO) &&
                           (i_req.addr <= `MMRD_EE_HI);
         o_rsp.hit      <= i_req.rd && (reg_hit[0] || id_hit);
         if (i_req.rd && id_hit) begin
            o_rsp.rdata <= PART_ID;
         end else if (i_req.rd && reg_hit[0]) begin
            o_rsp.rdata <= regs_q[hit_idx];
         end else begin
            o_rsp.rdata <= 8'h00;
         end
      end
   end

   // ------------------------------------------------------------
   // power mode clear strobe
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_pmc_strobe <= 1'b0;
      end else begin
         o_pmc_strobe <= i_req.wr && (i_req.addr == `MMRD_PMC);
      end
   end

   // ------------------------------------------------------------
   // vector address
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_vec_addr <= `MMRD_VEC_ADC;
      end else begin
         unique case (i_vec_sel)
            MMRD_VEC_TICK_E: o_vec_addr <= `MMRD_VEC_TICK;
            MMRD_VEC_PWM_E:  o_vec_addr <= `MMRD_VEC_PWM;
            MMRD_VEC_WAKE_E: o_vec_addr <= `MMRD_VEC_WAKE;
            MMRD_VEC_SWI_E:  o_vec_addr <= `MMRD_VEC_SWI;
            MMRD_VEC_ADC_E:  o_vec_addr <= `MMRD_VEC_ADC;
            default:         o_vec_addr <= `MMRD_VEC_ADC;
         endcase
      end
   end

   // ------------------------------------------------------------
   // steering outputs
   // ------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         o_trim_vol <= `MMRD_TRIM_FACTORY;
         o_init_vol <= `MMRD_RST_ZERO;
         o_port_out <= `MMRD_RST_ZERO;
         o_port_dir <= `MMRD_RST_ZERO;
         o_gie      <= 1'b0;
      end else begin
         o_trim_vol <= regs_q[25];
         o_init_vol <= regs_q[24];
         o_port_out <= regs_q[18];
         o_port_dir <= regs_q[19];
         o_gie      <= regs_q[33][4];
      end
   end

endmodule
`default_nettype wire

// File: test/mmrd_checker.sv
// Purpose: port level checks of the register decode
// Assumes: single clock, sync active low reset
// Notes:   bound onto mmrd_decode below
`timescale 1ns/1ns
`default_nettype none
module mmrd_checker (
   input wire logic                i_clk,
   input wire logic                i_rst_b,
   input wire mmrd_pkg::mmrd_req_t i_req,
   input wire logic                i_prog_mode,
   input wire mmrd_pkg::mmrd_vec_t i_vec_sel,
   input wire mmrd_pkg::mmrd_rsp_t o_rsp,
   input wire logic [11:0]         o_vec_addr,
   input wire logic [7:0]          o_trim_vol,
   input wire logic [7:0]          o_port_out,
   input wire logic                o_gie,
   input wire logic                o_pmc_strobe
);
   import mmrd_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   property p_unmap;
      i_req.rd && i_req.addr inside {[8'h80:8'h9C]} |=> o_rsp.rdata == 8'h00 && !o_rsp.hit;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_sram;
      (i_req.rd || i_req.wr) && i_req.addr <= 8'h3F |=> o_rsp.sram_sel && !o_rsp.ee_sel;
   endproperty
   a_sram: assert property (p_sram) else $error("sram select");
   property p_vec;
      i_vec_sel == MMRD_VEC_TICK_E |-> ##[1:2] o_vec_addr == 12'hFF6;
   endproperty
   a_vec: assert property (p_vec) else $error("tick vector");
   property p_trim_rst;
      $rose(i_rst_b) |-> o_trim_vol == 8'h80;
   endproperty
   a_trim_rst: assert property (p_trim_rst) else $error("trim reload");
   property p_init_rd;
      i_req.rd && i_req.addr == 8'hBB && !i_prog_mode |=> o_rsp.rdata == 8'h00;
   endproperty
   a_init_rd: assert property (p_init_rd) else $error("init read open");
   property p_pmc;
      i_req.wr && i_req.addr == 8'hC0 |-> ##[1:2] o_pmc_strobe;
   endproperty
   a_pmc: assert property (p_pmc) else $error("pmc strobe");
   property p_port;
      i_req.wr && i_req.addr == 8'hB2 |-> ##2 o_port_out == $past(i_req.wdata, 2);
   endproperty
   a_port: assert property (p_port) else $error("port data");
   property p_gie;
      i_req.wr && i_req.addr == 8'hCF |-> ##2 o_gie == $past(i_req.wdata[7], 2);
   endproperty
   a_gie: assert property (p_gie) else $error("gie write");
endmodule
bind mmrd_decode mmrd_checker chk_u (.i_clk, .i_rst_b, .i_req, .i_prog_mode, .i_vec_sel,
   .o_rsp, .o_vec_addr, .o_trim_vol, .o_port_out, .o_gie, .o_pmc_strobe);
`default_nettype wire

// File: test/mmrd_core_model.sv
// Purpose: core load/store path issuing one access at a time
// Assumes: request taken at the next rising edge
// Notes:   answer sampled just after the taking edge
`timescale 1ns/1ns
`default_nettype none
module mmrd_core_model (
   input  wire logic                i_clk,
   input  wire mmrd_pkg::mmrd_rsp_t i_rsp,
   output var  mmrd_pkg::mmrd_req_t o_req
);
   import mmrd_pkg::*;
   initial o_req = '0;
   task automatic xfer(input logic w, input logic [7:0] a, d, output mmrd_rsp_t r);
      @(posedge i_clk);
      #1 o_req = '{~w, w, a, d};
      @(posedge i_clk);
      #1 o_req = '0;
      r = i_rsp;
   endtask
endmodule
`default_nettype wire

// File: test/memory_mapped_register_decode_bench.sv
// Purpose: self checking bench of the register decode
// Assumes: core model drives the request port
// Notes:   hardware levels held constant
`timescale 1ns/1ns
`default_nettype none
module memory_mapped_register_decode_bench;
   import mmrd_pkg::*;
   logic i_clk, i_rst_b, i_prog_mode, o_gie, o_pmc_strobe;
   mmrd_req_t i_req;
   mmrd_rsp_t o_rsp, r;
   mmrd_hw_t i_hw;
   mmrd_vec_t i_vec_sel;
   logic [11:0] o_vec_addr;
   logic [7:0] o_trim_vol, o_init_vol, o_port_out, o_port_dir;
   int miscompares, n_checks, cyc;
   logic [7:0] al [7] = '{8'h9F, 8'hA4, 8'hA6, 8'hAA, 8'hB3, 8'hBF, 8'hCE};
   logic [7:0] il [8] = '{8'hB9, 8'hBB, 8'hBC, 8'hD0, 8'hD1, 8'hD3, 8'hD4, 8'hBA};
   mmrd_decode dut_u (.i_clk, .i_rst_b, .i_req, .i_prog_mode, .i_hw, .i_vec_sel, .o_rsp,
      .o_vec_addr, .o_trim_vol, .o_init_vol, .o_port_out, .o_port_dir, .o_gie, .o_pmc_strobe);
   mmrd_core_model core_u (.i_clk, .i_rsp(o_rsp), .o_req(i_req));
   task automatic chk(input logic [11:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      core_u.xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, e);
      core_u.xfer(1'b0, a, 8'h00, r);
      chk(r.rdata, e);
   endtask
   task automatic do_reset;
      i_rst_b = 1'b0;
      repeat (6) @(posedge i_clk);
      #1 i_rst_b = 1'b1;
   endtask
   task automatic final_report;
      if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_regs;
      foreach (al[i]) wr(al[i], al[i] ^ 8'h5A);
      foreach (al[i]) rd(al[i], al[i] ^ 8'h5A);
      wr(8'hB2, 8'h3C);
      rd(8'hB2, 8'h3C);
      chk(o_port_out, 8'h3C);
      chk(o_port_dir, 8'hE9);
      rd(8'hAC, 8'hA5);
      rd(8'hAD, 8'h03);
      wr(8'hBD, 8'hFF);
      rd(8'hBD, 8'hFD);
      rd(8'hD2, 8'h5A);
      wr(8'h9D, 8'h00);
      rd(8'h9D, 8'hC3);
      rd(8'hB4, 8'h6E);
      wr(8'hC0, 8'h01);
      chk(o_pmc_strobe, 1'b1);
   endtask
   task automatic t_unmap;
      wr(8'h90, 8'hFF);
      rd(8'h90, 8'h00);
      chk(r.hit, 1'b0);
      wr(8'h10, 8'h77);
      chk({r.sram_sel, r.ee_sel}, 2'b10);
      wr(8'h50, 8'h77);
      chk({r.sram_sel, r.ee_sel}, 2'b01);
   endtask
   task automatic t_init;
      wr(8'hB9, 8'hFF);
      wr(8'hBA, 8'h12);
      rd(8'hBB, 8'h00);
      chk(o_init_vol, 8'h00);
      chk(o_trim_vol, 8'h80);
      i_prog_mode = 1'b1;
      foreach (il[i]) wr(il[i], il[i] ^ 8'h33);
      foreach (il[i]) rd(il[i], il[i] ^ 8'h33);
      chk(o_trim_vol, 8'h89);
      chk(o_init_vol, 8'h8A);
      i_prog_mode = 1'b0;
      do_reset();
      chk(o_trim_vol, 8'h80);
   endtask
   task automatic t_status;
      wr(8'hCF, 8'hFF);
      rd(8'hCF, 8'h9F);
      chk(o_gie, 1'b1);
      wr(8'hCF, 8'h00);
      rd(8'hCF, 8'h8F);
   endtask
   task automatic t_vec;
      for (int i = 0; i < 5; i++) begin
         i_vec_sel = mmrd_vec_t'(5'h01 << i);
         repeat (3) @(posedge i_clk);
         #1 chk(o_vec_addr, 12'hFF6 + 12'(2 * i));
      end
   endtask
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         final_report();
      end
   end
   initial begin
      i_prog_mode = 1'b0;
      i_hw = '{8'h8F, 8'hC3, 12'h3A5, 8'h6E, 2'b01};
      i_vec_sel = MMRD_VEC_ADC_E;
      do_reset();
      t_regs();
      t_unmap();
      t_init();
      t_status();
      t_vec();
      final_report();
   end
endmodule
`default_nettype wire
